//--- slopc_pkg.sv
// package for the sixteen lane optical sublayer control block
// Summary of operation
// R1: sixteen transmit lanes, each its own output
// R2: symbol one drives high optical level
// R3: sixteen receive lanes handed up separately
// R4: high optical level reads as one
// R5: global detect level plus change pulse
// R6: any lane below threshold forces fail
// R7: no fixed detection latency relied upon
// R8: per-lane detect flag from own lane
// R9: management reset clears sublayer state
// R10: global disable turns off all transmitters
// R11: fault may force all transmitters off
// R12: lane disable turns off that lane only
// R13: other lane disable means optional
// R14: summary fault on any local fault
// R15: transmit fault on transmitter fault
// R16: receive fault on receiver fault
// R17: electrical lane i maps optical lane i
// R18: global detect is AND of lanes
// R19: disable bits at 1.9 and 1.27
// R20: detect bits at 1.10 and 1.28
// R21: fault bits at 1.1.7, 1.8.11, 1.8.10
// R22: software writes reset bit 1.0.15
`default_nettype none
package slopc_pkg;
   localparam int unsigned SLOPC_LANES = 16;
   localparam logic [4:0] SLOPC_REG_CTRL1 = 5'h00;
   localparam logic [4:0] SLOPC_REG_STAT1 = 5'h01;
   localparam logic [4:0] SLOPC_REG_STAT2 = 5'h08;
   localparam logic [4:0] SLOPC_REG_TXDIS = 5'h09;
   localparam logic [4:0] SLOPC_REG_SIGDET = 5'h0A;
   localparam logic [4:0] SLOPC_REG_TXDIS_EXT = 5'h1B;
   localparam logic [4:0] SLOPC_REG_SIGDET_EXT = 5'h1C;
   localparam logic [4:0] SLOPC_REG_FAULT_CFG = 5'h1D;
   localparam int unsigned SLOPC_BIT_RESET = 15;
   localparam int unsigned SLOPC_BIT_FAULT = 7;
   localparam int unsigned SLOPC_BIT_TX_FAULT = 11;
   localparam int unsigned SLOPC_BIT_RX_FAULT = 10;
   localparam logic [15:0] SLOPC_TXDIS_RESET = 16'h0000;
   localparam logic SLOPC_AUTO_OFF_RESET = 1'b0;
endpackage
`default_nettype wire

//--- slopc_top.sv
// sixteen lane optical sublayer control and status logic
`default_nettype none
module slopc_top (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [4:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   input wire logic [slopc_pkg::SLOPC_LANES-1:0] tx_bit_in,
   output logic [slopc_pkg::SLOPC_LANES-1:0] tx_light_out,
   input wire logic [slopc_pkg::SLOPC_LANES-1:0] rx_light_in,
   output logic [slopc_pkg::SLOPC_LANES-1:0] rx_bit_out,
   input wire logic [slopc_pkg::SLOPC_LANES-1:0] lane_power_ok_in,
   input wire logic [slopc_pkg::SLOPC_LANES-1:0] tx_lane_fault_in,
   input wire logic [slopc_pkg::SLOPC_LANES-1:0] rx_lane_fault_in,
   output logic signal_detect_out,
   output logic signal_change_out,
   output logic sublayer_reset_out
);
   import slopc_pkg::*;
   localparam int unsigned N = SLOPC_LANES;

   logic [N-1:0] tx_q, rx_s1_q, rx_q, pwr_s1_q, pwr_q;
   logic [N-1:0] txf_s1_q, txf_q, rxf_s1_q, rxf_q;
   logic [N-1:0] txdis_q, txdis_d;
   logic glob_dis_q, glob_dis_d, auto_off_q, auto_off_d;
   logic txf_lat_q, rxf_lat_q, sd_q, chg_q, srst_q, rdv_q;
   logic [15:0] rdata_q, rd_mux;

   // management reset pulse from control write
   wire soft_rst = wr_in && (addr_in == SLOPC_REG_CTRL1) && wdata_in[SLOPC_BIT_RESET]; // see R9 see R22
   wire wr_txdis = wr_in && (addr_in == SLOPC_REG_TXDIS); // see R19
   wire wr_txext = wr_in && (addr_in == SLOPC_REG_TXDIS_EXT);
   wire wr_cfg = wr_in && (addr_in == SLOPC_REG_FAULT_CFG);
   wire tx_fault_now = |txf_q; // see R15
   wire rx_fault_now = |rxf_q; // see R16
   wire any_fault = tx_fault_now | rx_fault_now | txf_lat_q | rxf_lat_q; // see R14
   wire glob_sd = &pwr_q; // see R6 see R18 see R7
   wire force_off = glob_dis_q | (auto_off_q & any_fault); // see R11
   wire [N-1:0] lane_off = txdis_q | {N{force_off}}; // see R10 see R12 see R13

   assign glob_dis_d = soft_rst ? 1'b0 : (wr_txdis ? wdata_in[0] : glob_dis_q);
   assign auto_off_d = soft_rst ? SLOPC_AUTO_OFF_RESET : (wr_cfg ? wdata_in[0] : auto_off_q);
   assign txdis_d = soft_rst ? SLOPC_TXDIS_RESET :
                    {(wr_txext ? wdata_in[0] : txdis_q[N-1]),
                     (wr_txdis ? wdata_in[15:1] : txdis_q[N-2:0])};

   // read decode; detect bits per lane
   always_comb begin
      rd_mux = 16'h0000;
      case (addr_in)
         SLOPC_REG_CTRL1: rd_mux = 16'h0000;
         SLOPC_REG_STAT1: rd_mux[SLOPC_BIT_FAULT] = any_fault; // see R21
         SLOPC_REG_STAT2: begin
            rd_mux[SLOPC_BIT_TX_FAULT] = tx_fault_now | txf_lat_q;
            rd_mux[SLOPC_BIT_RX_FAULT] = rx_fault_now | rxf_lat_q;
         end
         SLOPC_REG_TXDIS: rd_mux = {txdis_q[N-2:0], glob_dis_q};
         SLOPC_REG_SIGDET: rd_mux = {pwr_q[N-2:0], glob_sd}; // see R8 see R20
         SLOPC_REG_TXDIS_EXT: rd_mux[0] = txdis_q[N-1];
         SLOPC_REG_SIGDET_EXT: rd_mux[0] = pwr_q[N-1];
         SLOPC_REG_FAULT_CFG: rd_mux[0] = auto_off_q;
         default: rd_mux = 16'h0000;
      endcase
   end

   // per-lane data paths, lane i to lane i
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_lane
         always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
               tx_q[i] <= 1'b0;
               rx_s1_q[i] <= 1'b0;
               rx_q[i] <= 1'b0;
            end else begin
               tx_q[i] <= tx_bit_in[i] & ~lane_off[i]; // see R1 see R2 see R17
               rx_s1_q[i] <= rx_light_in[i];
               rx_q[i] <= rx_s1_q[i]; // see R3 see R4
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pwr_s1_q <= '0;
         pwr_q <= '0;
         txf_s1_q <= '0;
         txf_q <= '0;
         rxf_s1_q <= '0;
         rxf_q <= '0;
      end else begin
         pwr_s1_q <= lane_power_ok_in;
         pwr_q <= pwr_s1_q;
         txf_s1_q <= tx_lane_fault_in;
         txf_q <= txf_s1_q;
         rxf_s1_q <= rx_lane_fault_in;
         rxf_q <= rxf_s1_q;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         txdis_q <= SLOPC_TXDIS_RESET;
         glob_dis_q <= 1'b0;
         auto_off_q <= SLOPC_AUTO_OFF_RESET;
      end else begin
         txdis_q <= txdis_d;
         glob_dis_q <= glob_dis_d;
         auto_off_q <= auto_off_d;
      end
   end

   // latched faults clear on status 2 read; new fault wins
   wire rd_stat2 = rd_in && (addr_in == SLOPC_REG_STAT2);
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         txf_lat_q <= 1'b0;
         rxf_lat_q <= 1'b0;
      end else begin
         txf_lat_q <= tx_fault_now | (txf_lat_q & ~rd_stat2 & ~soft_rst); // see R15
         rxf_lat_q <= rx_fault_now | (rxf_lat_q & ~rd_stat2 & ~soft_rst); // see R16
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sd_q <= 1'b0;
         chg_q <= 1'b0;
         srst_q <= 1'b0;
         rdv_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         sd_q <= glob_sd;
         chg_q <= glob_sd ^ sd_q; // see R5
         srst_q <= soft_rst;
         rdv_q <= rd_in;
         rdata_q <= rd_in ? rd_mux : 16'h0000;
      end
   end

   assign tx_light_out = tx_q;
   assign rx_bit_out = rx_q;
   assign signal_detect_out = sd_q; // see R5
   assign signal_change_out = chg_q;
   assign sublayer_reset_out = srst_q;
   assign rdata_out = rdv_q ? rdata_q : 16'h0000;
endmodule
`default_nettype wire

//--- slopc_checker.sv
// assertion checker for the optical lane block
`default_nettype none
module slopc_checker (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic signal_detect_out,
   input wire logic signal_change_out,
   input wire logic sublayer_reset_out,
   input wire logic [4:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic [15:0] rdata_out,
   input wire logic [15:0] tx_bit_in,
   input wire logic [15:0] tx_light_out,
   input wire logic [15:0] rx_light_in,
   input wire logic [15:0] rx_bit_out,
   input wire logic [15:0] lane_power_ok_in
);
   import slopc_pkg::*;
   logic [1:0] up_q;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence dis_wr;
      wr_in && addr_in == SLOPC_REG_TXDIS;
   endsequence
   sequence ext_wr;
      wr_in && addr_in == SLOPC_REG_TXDIS_EXT && wdata_in[0];
   endsequence
   always_ff @(posedge clk_in or posedge rst_in)
      if (rst_in) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   chk_tx_follow: assert property (up_q == 2'h3 |-> (tx_light_out & ~$past(tx_bit_in)) == 16'h0000)
      else $error("tx");
   chk_rx_follow: assert property (up_q == 2'h3 |-> rx_bit_out == $past(rx_light_in, 2))
      else $error("rx");
   chk_det_and: assert property (up_q == 2'h3 |-> signal_detect_out == &$past(lane_power_ok_in, 3))
      else $error("det");
   chk_det_event: assert property (up_q == 2'h3 |-> signal_change_out == $changed(signal_detect_out))
      else $error("chg");
   chk_soft_rst: assert property (up_q != 2'h0 |-> sublayer_reset_out ==
      $past(wr_in && addr_in == SLOPC_REG_CTRL1 && wdata_in[SLOPC_BIT_RESET])) else $error("rst");
   chk_ctrl_read: assert property ($past(rd_in && addr_in == SLOPC_REG_CTRL1) |-> rdata_out == 16'h0000)
      else $error("rd0");
   chk_all_off: assert property (dis_wr ##0 wdata_in[0] |-> ##2 tx_light_out == 16'h0000)
      else $error("gdis");
   chk_lane_off: assert property (dis_wr |-> ##2 (tx_light_out[14:0] & $past(wdata_in[15:1], 2)) == 15'h0000)
      else $error("ldis");
   chk_lane15_off: assert property (ext_wr |-> ##2 !tx_light_out[15])
      else $error("ldis15");
endmodule
bind slopc_top slopc_checker i_chk (.*);
`default_nettype wire

//--- slopc_pma.sv
// upper sublayer model sending lane symbols
`default_nettype none
module slopc_pma (
   input wire logic clk_in,
   input wire logic rst_in,
   output logic [15:0] tx_bit_out
);
   always_ff @(posedge clk_in or posedge rst_in)
      if (rst_in) tx_bit_out <= 16'hA5C3;
      else tx_bit_out <= {tx_bit_out[14:0], tx_bit_out[15]};
endmodule
`default_nettype wire

//--- slopc_bench.sv
// self-checking bench for the optical lane block
`default_nettype none
module slopc_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import slopc_pkg::*;
   logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
   logic signal_detect_out, signal_change_out, sublayer_reset_out;
   logic [4:0] addr_in = 5'h00;
   logic [15:0] wdata_in = 16'h0000, lane_power_ok_in = 16'hFFFF;
   logic [15:0] tx_lane_fault_in = 16'h0000, rx_lane_fault_in = 16'h0000;
   logic [15:0] rdata_out, tx_bit_in, tx_light_out, rx_bit_out, got, prev_bit;
   wire logic [15:0] rx_light_in = tx_light_out;
   int n_fail = 0, num_checks = 0;
   always #5 clk_in = ~clk_in;
   slopc_pma i_pma (.clk_in(clk_in), .rst_in(rst_in), .tx_bit_out(tx_bit_in));
   always @(posedge clk_in) prev_bit <= tx_bit_in;
   slopc_top i_dut (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .wr_in(wr_in),
      .rd_in(rd_in),
      .rdata_out(rdata_out),
      .tx_bit_in(tx_bit_in),
      .tx_light_out(tx_light_out),
      .rx_light_in(rx_light_in),
      .rx_bit_out(rx_bit_out),
      .lane_power_ok_in(lane_power_ok_in),
      .tx_lane_fault_in(tx_lane_fault_in),
      .rx_lane_fault_in(rx_lane_fault_in),
      .signal_detect_out(signal_detect_out),
      .signal_change_out(signal_change_out),
      .sublayer_reset_out(sublayer_reset_out)
   );
   task automatic chk(input logic [15:0] g, e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_in);
      wr_in <= w;
      rd_in <= !w;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      @(posedge clk_in);
      got = rdata_out;
   endtask
   task automatic t_detect;
      bus(1'b0, SLOPC_REG_SIGDET_EXT, 16'h0000);
      chk(got, 16'h0001);
      bus(1'b0, SLOPC_REG_SIGDET, 16'h0000);
      chk(got, 16'hFFFF);
      lane_power_ok_in <= 16'hFFDF;
      repeat (4) @(posedge clk_in);
      chk({15'h0000, signal_detect_out}, 16'h0000);
      bus(1'b0, SLOPC_REG_SIGDET, 16'h0000);
      chk(got, 16'hFFBE);
      lane_power_ok_in <= 16'h7FFF;
      repeat (4) @(posedge clk_in);
      bus(1'b0, SLOPC_REG_SIGDET_EXT, 16'h0000);
      chk(got, 16'h0000);
      lane_power_ok_in <= 16'hFFFF;
   endtask
   task automatic t_disable;
      bus(1'b1, SLOPC_REG_TXDIS, 16'h0001);
      bus(1'b0, SLOPC_REG_TXDIS, 16'h0000);
      chk(got, 16'h0001);
      bus(1'b1, SLOPC_REG_TXDIS, 16'h0004);
      bus(1'b1, SLOPC_REG_TXDIS_EXT, 16'h0001);
      bus(1'b0, SLOPC_REG_TXDIS_EXT, 16'h0000);
      chk(got, 16'h0001);
      chk(tx_light_out, prev_bit & 16'h7FFD);
   endtask
   task automatic t_fault;
      tx_lane_fault_in <= 16'h0008;
      repeat (3) @(posedge clk_in);
      bus(1'b0, SLOPC_REG_STAT1, 16'h0000);
      chk(got & 16'h0080, 16'h0080);
      bus(1'b0, SLOPC_REG_STAT2, 16'h0000);
      chk(got & 16'h0800, 16'h0800);
      tx_lane_fault_in <= 16'h0000;
      rx_lane_fault_in <= 16'h0100;
      repeat (3) @(posedge clk_in);
      bus(1'b0, SLOPC_REG_STAT2, 16'h0000);
      chk(got & 16'h0400, 16'h0400);
      rx_lane_fault_in <= 16'h0000;
   endtask
   task automatic t_auto_off;
      bus(1'b1, SLOPC_REG_FAULT_CFG, 16'h0001);
      bus(1'b0, SLOPC_REG_FAULT_CFG, 16'h0000);
      chk(got, 16'h0001);
      rx_lane_fault_in <= 16'h0001;
      repeat (4) @(posedge clk_in);
      chk(tx_light_out, 16'h0000);
      bus(1'b0, SLOPC_REG_TXDIS, 16'h0000);
      chk(got, 16'h0004);
      bus(1'b1, SLOPC_REG_FAULT_CFG, 16'h0000);
      rx_lane_fault_in <= 16'h0000;
   endtask
   task automatic t_reset;
      bus(1'b1, SLOPC_REG_TXDIS, 16'h0006);
      bus(1'b1, SLOPC_REG_CTRL1, 16'h8000);
      bus(1'b0, SLOPC_REG_TXDIS, 16'h0000);
      chk(got, 16'h0000);
      bus(1'b0, SLOPC_REG_CTRL1, 16'h0000);
      chk(got, 16'h0000);
      bus(1'b0, 5'h1F, 16'h0000);
      chk(got, 16'h0000);
      chk(tx_light_out, {tx_bit_in[0], tx_bit_in[15:1]});
      chk(rx_bit_out, {tx_light_out[1:0], tx_light_out[15:2]});
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      t_detect;
      t_disable;
      t_fault;
      t_auto_off;
      t_reset;
      give_verdict;
   end
   initial begin
      #100000;
      n_fail++;
      give_verdict;
   end
endmodule
`default_nettype wire
